//--- src/i2cfe_top.sv
// Purpose: i2c target front end giving register index, byte select and strobes
// Assumes: core drives rd_data and reg_width_m1 from register_index and byte_sel
// Notes: sda is open drain; sda_oe high means pulling the line low
module i2cfe_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic device_select_pin_2,
  input wire logic device_select_pin_1,
  input wire logic device_select_pin_0,
  input wire logic [7:0] rd_data,
  input wire logic [1:0] reg_width_m1,
  output logic sda_out,
  output logic sda_oe,
  output logic [3:0] register_index,
  output logic [1:0] byte_sel,
  output logic [7:0] wr_data,
  output logic wr_strobe,
  output logic rd_strobe
);
  // next index in a sequential access
  function automatic logic [3:0] next_index(input logic [3:0] idx, input logic is_read);
    logic [3:0] n;
    n = 4'h0;
    if (is_read)
    begin
      n = (idx == i2cfe_pkg::READ_LAST_IDX) ? i2cfe_pkg::REG_IDX_RESET : idx + 4'h1; // R11
      if (n == i2cfe_pkg::TRANSFER_IDX)
        n = n + 4'h1; // R10
    end
    else
      n = (idx == i2cfe_pkg::WRITE_LAST_IDX) ? i2cfe_pkg::REG_IDX_RESET : idx + 4'h1; // R12
    return n;
  endfunction

  i2cfe_pkg::i2cfe_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic read_reg;
  logic auto_reg;
  logic single_done_reg;
  logic load_sel_reg;
  logic [3:0] idx_reg;
  logic [1:0] byte_sel_reg;
  logic [7:0] wr_data_reg;
  logic wr_strobe_reg;
  logic rd_strobe_reg;
  logic sda_oe_reg;
  logic sda_out_reg;

  wire logic sda_s;
  wire logic scl_rise;
  wire logic scl_fall;
  wire logic start_seen;
  wire logic stop_seen;
  wire logic [2:0] sel_s;

  i2cfe_line_mon u_mon (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .scl_pin(scl_in),
    .sda_pin(sda_in),
    .sel_pins({device_select_pin_2, device_select_pin_1, device_select_pin_0}),
    .sda_level(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen),
    .sel_level(sel_s)
  );

  wire logic receiving = (state_reg == i2cfe_pkg::ST_ADDR) || (state_reg == i2cfe_pkg::ST_RSEL)
    || (state_reg == i2cfe_pkg::ST_WDATA);
  wire logic byte_in_done = (bit_cnt_reg == i2cfe_pkg::BITS_PER_BYTE) && scl_fall;
  wire logic [6:0] addr_rx = shift_reg[7:1];
  wire logic own_hit = addr_rx == {i2cfe_pkg::DEV_ADDR_HI, sel_s}; // R1
  wire logic bcast_hit = (addr_rx[6:3] == i2cfe_pkg::BCAST_ADDR_HI)
    && (shift_reg[0] == i2cfe_pkg::DIR_WRITE); // R2 R3
  wire logic addr_ok = own_hit || bcast_hit;
  wire logic reg_last = byte_sel_reg == 2'h0;
  wire logic [3:0] wr_adv = next_index(idx_reg, 1'b0);
  wire logic [3:0] rd_adv = next_index(idx_reg, 1'b1);

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_reg <= i2cfe_pkg::ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      read_reg <= 1'b0;
      auto_reg <= 1'b0;
      single_done_reg <= 1'b0;
      load_sel_reg <= 1'b1;
      idx_reg <= i2cfe_pkg::REG_IDX_RESET;
      byte_sel_reg <= i2cfe_pkg::BYTE_SEL_RESET;
      wr_data_reg <= 8'h00;
      wr_strobe_reg <= 1'b0;
      rd_strobe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      sda_out_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      wr_strobe_reg <= 1'b0;
      rd_strobe_reg <= 1'b0;
      load_sel_reg <= 1'b0;
      sda_out_reg <= 1'b0;
      // width is fetched a cycle after the index settles; scl is far slower
      if (load_sel_reg)
        byte_sel_reg <= reg_width_m1; // R13
      if (stop_seen)
      begin
        state_reg <= i2cfe_pkg::ST_IDLE; // R14
        sda_oe_reg <= 1'b0;
        idx_reg <= i2cfe_pkg::REG_IDX_RESET; // R15
        load_sel_reg <= 1'b1;
      end
      else if (start_seen)
      begin
        // repeated start keeps the index for a read after a select byte
        state_reg <= i2cfe_pkg::ST_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe_reg <= 1'b0;
      end
      else
      begin
        if (receiving && scl_rise)
        begin
          shift_reg <= {shift_reg[6:0], sda_s};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
        case (state_reg)
          i2cfe_pkg::ST_ADDR:
            if (byte_in_done)
            begin
              if (addr_ok)
              begin
                read_reg <= shift_reg[0]; // R3
                sda_oe_reg <= 1'b1; // R4
                state_reg <= i2cfe_pkg::ST_ADDR_ACK;
              end
              else
                state_reg <= i2cfe_pkg::ST_IDLE;
            end
          i2cfe_pkg::ST_ADDR_ACK:
            if (scl_fall)
            begin
              bit_cnt_reg <= 4'h0;
              if (read_reg)
              begin
                shift_reg <= rd_data;
                sda_oe_reg <= !rd_data[7]; // R13
                rd_strobe_reg <= 1'b1;
                state_reg <= i2cfe_pkg::ST_RDATA;
              end
              else
              begin
                sda_oe_reg <= 1'b0;
                state_reg <= i2cfe_pkg::ST_RSEL;
              end
            end
          i2cfe_pkg::ST_RSEL:
            if (byte_in_done)
            begin
              idx_reg <= shift_reg[3:0]; // R5
              auto_reg <= shift_reg[i2cfe_pkg::RSEL_AUTO_BIT]; // R5
              single_done_reg <= 1'b0;
              load_sel_reg <= 1'b1;
              sda_oe_reg <= 1'b1; // R4
              state_reg <= i2cfe_pkg::ST_RSEL_ACK;
            end
          i2cfe_pkg::ST_RSEL_ACK, i2cfe_pkg::ST_WACK:
            if (scl_fall)
            begin
              sda_oe_reg <= 1'b0;
              bit_cnt_reg <= 4'h0;
              state_reg <= i2cfe_pkg::ST_WDATA;
            end
          i2cfe_pkg::ST_WDATA:
            if (byte_in_done)
            begin
              // bytes past a finished single register are refused with a nack
              if (!single_done_reg)
              begin
                wr_data_reg <= shift_reg;
                wr_strobe_reg <= 1'b1;
                sda_oe_reg <= 1'b1; // R4
                state_reg <= i2cfe_pkg::ST_WACK;
                if (reg_last)
                begin
                  if (auto_reg)
                  begin
                    idx_reg <= wr_adv; // R8 R9 R12
                    load_sel_reg <= 1'b1;
                  end
                  else
                    single_done_reg <= 1'b1; // R7
                end
                else
                  byte_sel_reg <= byte_sel_reg - 2'h1; // R13
              end
              else
                state_reg <= i2cfe_pkg::ST_IDLE; // R7
            end
          i2cfe_pkg::ST_RDATA:
            if (scl_fall)
            begin
              if (bit_cnt_reg == i2cfe_pkg::LAST_TX_BIT)
              begin
                sda_oe_reg <= 1'b0;
                bit_cnt_reg <= 4'h0;
                state_reg <= i2cfe_pkg::ST_RACK;
                if (reg_last)
                begin
                  // a single register read repeats itself from its top byte
                  if (auto_reg)
                    idx_reg <= rd_adv; // R8 R9 R10 R11
                  load_sel_reg <= 1'b1; // R7
                end
                else
                  byte_sel_reg <= byte_sel_reg - 2'h1; // R13
              end
              else
              begin
                shift_reg <= {shift_reg[6:0], 1'b0};
                sda_oe_reg <= !shift_reg[6];
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          i2cfe_pkg::ST_RACK:
            if (scl_rise)
            begin
              if (sda_s)
                state_reg <= i2cfe_pkg::ST_IDLE; // R14
              else
                bit_cnt_reg <= i2cfe_pkg::BITS_PER_BYTE;
            end
            else if (scl_fall && (bit_cnt_reg == i2cfe_pkg::BITS_PER_BYTE))
            begin
              shift_reg <= rd_data;
              sda_oe_reg <= !rd_data[7]; // R13
              rd_strobe_reg <= 1'b1;
              bit_cnt_reg <= 4'h0;
              state_reg <= i2cfe_pkg::ST_RDATA;
            end
          i2cfe_pkg::ST_IDLE:
            sda_oe_reg <= 1'b0;
          default:
            state_reg <= i2cfe_pkg::ST_IDLE;
        endcase
      end
    end
  end

  assign sda_out = sda_out_reg;
  assign sda_oe = sda_oe_reg;
  assign register_index = idx_reg;
  assign byte_sel = byte_sel_reg;
  assign wr_data = wr_data_reg;
  assign wr_strobe = wr_strobe_reg;
  assign rd_strobe = rd_strobe_reg;
endmodule

//--- src/i2cfe_pkg.sv
// Purpose: shared constants and types of the i2c register front end
// Assumes: 50 MHz clock, bus clock driven by an external master
// Notes: no software registers; core reached through index, byte select and strobes
//
// Overview of operation
// (R1) accept address 1110 plus three select pins
// (R2) accept broadcast write address 0000xxx, acknowledge
// (R3) direction 0 writes, 1 reads; broadcast writes only
// (R4) receiver acknowledges every good byte
// (R5) select byte: 000, auto flag, index nibble
// (R6) master uses index 0000 through 1000 only
// (R7) flag clear: stay on the single register
// (R8) flag set: advance index after each register
// (R9) multi-byte register advances after its last byte
// (R10) sequential reads skip the transfer register
// (R11) sequential reads wrap to 0000 after 1000
// (R12) sequential writes wrap to 0000 after 0101
// (R13) multi-byte values move most significant first
// (R14) nack or stop ends cycle until start
// (R15) stop resets register index to zero
// (R16) sync lines, detect start and stop
package i2cfe_pkg;
  localparam logic [3:0] DEV_ADDR_HI = 4'he;
  localparam logic [3:0] BCAST_ADDR_HI = 4'h0;
  localparam logic DIR_WRITE = 1'b0;
  localparam int RSEL_AUTO_BIT = 4;
  localparam logic [3:0] REG_IDX_RESET = 4'h0;
  localparam logic [3:0] READ_LAST_IDX = 4'h8;
  localparam logic [3:0] WRITE_LAST_IDX = 4'h5;
  localparam logic [3:0] TRANSFER_IDX = 4'h3;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam logic [1:0] BYTE_SEL_RESET = 2'h0;

  typedef enum logic [8:0] {
    ST_IDLE     = 9'b0_0000_0001,
    ST_ADDR     = 9'b0_0000_0010,
    ST_ADDR_ACK = 9'b0_0000_0100,
    ST_RSEL     = 9'b0_0000_1000,
    ST_RSEL_ACK = 9'b0_0001_0000,
    ST_WDATA    = 9'b0_0010_0000,
    ST_WACK     = 9'b0_0100_0000,
    ST_RDATA    = 9'b0_1000_0000,
    ST_RACK     = 9'b1_0000_0000
  } i2cfe_state_t;
endpackage

//--- src/i2cfe_line_mon.sv
// Purpose: synchronise bus lines and select pins, find edges, start and stop
// Assumes: inputs asynchronous to clock
// Notes: start and stop need two stable samples of a high bus clock
module i2cfe_line_mon (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire logic [2:0] sel_pins,
  output logic sda_level,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_seen,
  output logic stop_seen,
  output logic [2:0] sel_level
);
  logic [4:0] meta_reg;
  logic [4:0] sync_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;

  wire logic [4:0] pin_raw = {sel_pins, sda_pin, scl_pin};

  // first stage feeds only the second stage
  genvar g;
  generate
    for (g = 0; g < 5; g++)
    begin : g_sync
      always_ff @(posedge clock)
      begin
        if (!rst_n)
        begin
          meta_reg[g] <= 1'b1;
          sync_reg[g] <= 1'b1;
        end
        else if (clk_en)
        begin
          meta_reg[g] <= pin_raw[g];
          sync_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else if (clk_en)
    begin
      scl_prev_reg <= sync_reg[0];
      sda_prev_reg <= sync_reg[1];
    end
  end

  wire logic scl_high = sync_reg[0] && scl_prev_reg;

  assign sda_level = sync_reg[1];
  assign sel_level = sync_reg[4:2];
  assign scl_rise = sync_reg[0] && !scl_prev_reg;
  assign scl_fall = !sync_reg[0] && scl_prev_reg;
  assign start_seen = scl_high && sda_prev_reg && !sync_reg[1]; // R16
  assign stop_seen = scl_high && !sda_prev_reg && sync_reg[1]; // R16
endmodule

//--- bench/i2cfe_monitor.sv
// Purpose: port checker of the i2c front end
// Assumes: bus clock far slower than clock
// Notes: bound to i2cfe_top
module i2cfe_monitor (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe,
  input wire logic [3:0] register_index,
  input wire logic [1:0] byte_sel,
  input wire logic [7:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // scl high 4 samples back keeps own ack edges out
  property p_stop;
    scl_in && $past(scl_in, 4) && $rose(sda_in) |-> ##6 register_index == 4'h0 && !sda_oe;
  endproperty
  a_stop: assert property (p_stop) else $error("stop");
  property p_start;
    scl_in && $past(scl_in, 4) && $fell(sda_in) |-> ##6 !sda_oe;
  endproperty
  a_start: assert property (p_start) else $error("start");
  property p_wack;
    wr_strobe |-> ##[0:2] sda_oe;
  endproperty
  a_wack: assert property (p_wack) else $error("ack");
  property p_pulse;
    wr_strobe || rd_strobe |=> !wr_strobe && !rd_strobe;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse");
  property p_whold;
    !wr_strobe |-> $stable(wr_data);
  endproperty
  a_whold: assert property (p_whold) else $error("hold");
  property p_down;
    wr_strobe && $past(byte_sel) != 2'h0
      |-> byte_sel == $past(byte_sel) - 2'h1 && $stable(register_index);
  endproperty
  a_down: assert property (p_down) else $error("byte");
  property p_range;
    register_index <= 4'h8;
  endproperty
  a_range: assert property (p_range) else $error("range");
  property p_skip;
    rd_strobe |-> register_index != 4'h3;
  endproperty
  a_skip: assert property (p_skip) else $error("skip");
endmodule
bind i2cfe_top i2cfe_monitor i_mon (.clock, .rst_n, .scl_in, .sda_in, .sda_oe,
  .register_index, .byte_sel, .wr_data, .wr_strobe, .rd_strobe);

//--- bench/i2cfe_master.sv
// Purpose: i2c bus master model
// Assumes: 160 ns bus clock, sda pulled up
// Notes: start adds 7 ns so bus edges miss clock edges
module i2cfe_master (
  output logic scl,
  output logic sda_rel,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic start();
    #7 sda_rel = 1'b1;
    // the target may still hold its ack 60 ns after the fall
    #80 scl = 1'b1;
    #100 sda_rel = 1'b0;
    #100 scl = 1'b0;
  endtask
  task automatic stop();
    sda_rel = 1'b0;
    #40 scl = 1'b1;
    #100 sda_rel = 1'b1;
    #100;
  endtask
  // data moves only while scl is low
  task automatic bit9(input logic b, output logic r);
    #40 sda_rel = b;
    #40 scl = 1'b1;
    #40 r = sda;
    #40 scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
    output logic k);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit9(d[i], r);
      q[i] = r;
    end
    bit9(a, k);
  endtask
endmodule

//--- bench/tb_i2cfe_top.sv
// Purpose: self-checking bench of the i2c front end
// Assumes: core modelled by functions of index and byte
// Notes: widths 4,4,2,4 bytes at 4,5,6,8, else 1
module tb_i2cfe_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] pins = 3'h0;
  logic scl;
  logic sda_rel;
  logic sda_oe;
  logic [3:0] register_index;
  logic [1:0] byte_sel;
  logic [7:0] wr_data;
  logic wr_strobe;
  logic rd_strobe;
  logic sda_out;
  logic clk_en = 1'b1;
  int rd_cnt = 0;
  logic [3:0] pidx;
  logic [1:0] pbs;
  wire sda_line = sda_rel & ~sda_oe;
  int error_cnt = 0;
  int compares = 0;
  integer seed = 32'h0000_8c00;
  int exp_q[$];
  logic [13:0] wq[$];
  function automatic int wid(input int i);
    return (i == 4 || i == 5 || i == 8) ? 3 : (i == 6 ? 1 : 0);
  endfunction
  function automatic logic [7:0] rdv(input int i, input int b);
    return 8'(i * 4 + b) ^ 8'h5a;
  endfunction
  function automatic int nxt(input int i, input bit rd);
    if (rd)
      return (i == 8) ? 0 : (i == 2 ? 4 : i + 1);
    return (i == 5) ? 0 : i + 1;
  endfunction
  task automatic plan(input int i, input bit f, input bit rd, input int n);
    int b;
    b = wid(i);
    exp_q = {};
    repeat (n)
    begin
      exp_q.push_back(i * 4 + b);
      if (b > 0)
        b--;
      else
      begin
        if (f)
          i = nxt(i, rd);
        b = wid(i);
      end
    end
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic txn(input logic [6:0] a, input int i, input bit f, input bit rd,
    input bit sp, input int n);
    logic [7:0] q;
    logic [7:0] d;
    logic k;
    int e;
    plan(sp ? 0 : i, f, rd, n);
    wq = {};
    rd_cnt = 0;
    m.start();
    m.xfer({a, 1'b0}, 1'b1, q, k);
    chk(k, 1'b0);
    m.xfer({3'h0, f, 4'(i)}, 1'b1, q, k);
    chk(k, 1'b0);
    if (sp)
      m.stop();
    if (rd)
    begin
      m.start();
      m.xfer({a, 1'b1}, 1'b1, q, k);
      chk(k, 1'b0);
    end
    for (int j = 0; j < n; j++)
    begin
      e = exp_q[j];
      d = 8'($random(seed));
      m.xfer(rd ? 8'hff : d, !rd || j == n - 1, q, k);
      if (rd)
        chk(q, rdv(e / 4, e % 4));
      else if (!f && j > wid(i))
        chk(k, 1'b1);
      else
        chk({k, wq.pop_front()}, {1'b0, 6'(e), d});
    end
    #100 chk(sda_oe, 1'b0);
    chk({sda_out, 15'(rd_cnt)}, {1'b0, 15'(rd ? n : 0)});
    m.stop();
    #400 chk({register_index, 12'(wq.size())}, 16'h0000);
    $display("test done compares=%0d", compares);
  endtask
  task automatic nak(input logic [7:0] a);
    logic [7:0] q;
    logic k;
    m.start();
    m.xfer(a, 1'b1, q, k);
    chk(k, 1'b1);
    m.stop();
    #400 chk(16'(wq.size()), 16'h0000);
    $display("test done compares=%0d", compares);
  endtask
  always #10 clock = ~clock;
  always @(posedge clock)
  begin
    if (wr_strobe)
      wq.push_back({pidx, pbs, wr_data});
    if (rd_strobe)
      rd_cnt++;
    pidx <= register_index;
    pbs <= byte_sel;
  end
  i2cfe_master m (.scl(scl), .sda_rel(sda_rel), .sda(sda_line));
  i2cfe_top i_dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .scl_in(scl),
    .sda_in(sda_line), .device_select_pin_2(pins[2]), .device_select_pin_1(pins[1]),
    .device_select_pin_0(pins[0]), .rd_data(rdv(register_index, byte_sel)),
    .reg_width_m1(2'(wid(register_index))), .sda_out(sda_out), .sda_oe(sda_oe),
    .register_index(register_index), .byte_sel(byte_sel), .wr_data(wr_data),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe));
  initial
  begin
    #400000;
    error_cnt++;
    print_verdict();
  end
  initial
  begin
    repeat (5) @(posedge clock);
    pins <= 3'($random(seed));
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    txn({4'he, pins}, 5, 0, 0, 0, 5);
    txn({4'h0, 3'($random(seed))}, 4, 1, 0, 0, 10);
    txn({4'he, pins}, 7, 1, 1, 0, 9);
    txn({4'he, pins}, 6, 0, 1, 0, 4);
    // a frozen target must not answer even its own address
    @(posedge clock);
    clk_en <= 1'b0;
    nak({4'he, pins, 1'b0});
    @(posedge clock);
    clk_en <= 1'b1;
    txn({4'he, pins}, 2, 0, 1, 1, 2);
    nak({4'he, ~pins, 1'b0});
    nak({4'hd, pins, 1'b0});
    nak({4'h0, pins, 1'b1});
    print_verdict();
  end
endmodule
